// ==== core/cpmc_pkg.sv ====
// Purpose: Constants and types for the privilege and mode control block
// Assumes: One core clock, 32-bit data words
// Notes:   Shared by the design and its bench
package cpmc_pkg;
    localparam int          CPMC_DATA_W     = 32;
    localparam int          CPMC_CTRL_W     = 2;
    // Control register fields
    localparam int          CPMC_CTRL_NPRIV = 0;
    localparam logic [1:0]  CPMC_CTRL_RST   = 2'h0;
    // Execution status register state bit
    localparam int          CPMC_ESR_STATE  = 24;
    localparam logic [31:0] CPMC_ESR_RST    = 32'h0100_0000;
    // Stack pointer alignment: low two bits read as zero
    localparam logic [31:0] CPMC_SP_MASK    = 32'hFFFF_FFFC;
    localparam logic [31:0] CPMC_SP_RST     = 32'h0000_0000;
    // Special register selectors for move-to/from-special accesses
    localparam logic [2:0]  CPMC_SEL_MSP    = 3'h0;
    localparam logic [2:0]  CPMC_SEL_PSP    = 3'h1;
    localparam logic [2:0]  CPMC_SEL_CTRL   = 3'h2;
    localparam logic [2:0]  CPMC_SEL_ESR    = 3'h3;
    // Bit-band alias: one word per SRAM bit
    localparam int          CPMC_BB_IDX_W   = 5;
    // Operating states; handler at user level does not exist
    typedef enum logic [1:0] {
        CPMC_PRIV_THREAD,
        CPMC_USER_THREAD,
        CPMC_PRIV_HANDLER
    } cpmc_state_t;
endpackage

// ==== core/cpmc_core.sv ====
// Purpose: Privilege level, thread/handler mode and stack pointer banking
// Assumes: Exception entry/return and accesses come from the pipeline
// Notes:   All requests are single-cycle pulses sampled on clk
`timescale 1ns/1ps

// Behaviour
// - Handler mode exists only at the privileged level; three legal states.
// - User level blocks protected accesses and raises a fault for each.
// - Privileged level allows protected instructions and registers; legacy encodings and clearing status bit 24 still fault.
// - Exceptions run in privileged handler mode; main program in thread.
// - Two stack pointers, main and process, selected by level and mode.
// - Decoder accepts only mixed 16/32-bit compact encodings, faults legacy.
// - Bit-band alias writes or reads one SRAM bit atomically.
// - Unaligned accesses supported; data packed contiguously by byte lanes.
// - External reset is active low, held high by a pull-up.
// - Process stack pointer only in user thread; main elsewhere.
// - Control bit 0 selects thread level: 0 privileged, 1 user.
// - Status bit 24 reads one at the privileged level (user reads return zero); clearing it raises a fault.
module cpmc_core
    import cpmc_pkg::*;
#(
    parameter int DATA_W = CPMC_DATA_W
) (
    // Clock and resets
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              external_reset_n,
    // Exception entry and return
    input  wire logic              exc_enter,
    input  wire logic              exc_return,
    // Instruction decode checks
    input  wire logic              instr_valid,
    input  wire logic              instr_legacy,
    input  wire logic              instr_protected,
    // Special register access
    input  wire logic              sreg_wr,
    input  wire logic              sreg_rd,
    input  wire logic [2:0]        sreg_sel,
    input  wire logic [DATA_W-1:0] sreg_wdata,
    // Protected resource access (config, debug)
    input  wire logic              prot_access,
    // Stack pointer update from push/pop
    input  wire logic              sp_wr,
    input  wire logic [DATA_W-1:0] sp_wdata,
    // Bit-band alias access
    input  wire logic              bb_wr,
    input  wire logic [CPMC_BB_IDX_W-1:0] bb_idx,
    input  wire logic              bb_bit,
    input  wire logic [DATA_W-1:0] bb_old_word,
    // Unaligned store packing
    input  wire logic [1:0]        st_offset,
    input  wire logic [DATA_W-1:0] st_data,
    // Outputs
    output logic [DATA_W-1:0]      sreg_rdata,
    output logic [DATA_W-1:0]      active_sp,
    output logic                   sp_is_process,
    output logic                   privileged,
    output logic                   handler_mode,
    output logic                   fault,
    output logic [DATA_W-1:0]      bb_new_word,
    output logic                   bb_rd_bit,
    output logic [2*DATA_W-1:0]    st_lanes
);
    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    cpmc_state_t             state_reg, state_next;
    logic [CPMC_CTRL_W-1:0]  ctrl_reg, ctrl_next;
    logic [DATA_W-1:0]       main_stack_pointer_reg, main_sp_next;
    logic [DATA_W-1:0]       process_stack_pointer_reg, proc_sp_next;
    logic                    fault_reg, fault_next;
    logic [DATA_W-1:0]       sreg_rdata_reg, rdata_next;
    logic [DATA_W-1:0]       bb_word_reg;
    logic                    bb_bit_reg;
    logic [2*DATA_W-1:0]     st_lanes_reg;

    // Internal reset merges the system and external reset pin
    wire rst_any = sys_rst | ~external_reset_n;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire is_user    = (state_reg == CPMC_USER_THREAD);
    wire is_handler = (state_reg == CPMC_PRIV_HANDLER);
    // Only user thread banks the process stack pointer
    wire use_psp    = is_user;
    // Protected touches: special regs, protected instrs, config/debug
    wire user_block = is_user & ((instr_valid & instr_protected) |
                      sreg_wr | sreg_rd | prot_access);
    // Legacy fixed-width encodings are never decoded
    wire legacy_flt = instr_valid & instr_legacy;
    // Clearing the state bit of the status register faults
    wire esr_clear  = ~is_user & sreg_wr & (sreg_sel == CPMC_SEL_ESR) &
                      ~sreg_wdata[CPMC_ESR_STATE];
    wire priv_wr    = ~is_user & sreg_wr;
    wire [DATA_W-1:0] sp_aligned = sp_wdata & DATA_W'(CPMC_SP_MASK);
    wire [DATA_W-1:0] sreg_al    = sreg_wdata & DATA_W'(CPMC_SP_MASK);

    // Next state: exceptions enter privileged handler, return to thread
    always_comb begin
        state_next = state_reg;
        ctrl_next  = ctrl_reg;
        if (priv_wr && sreg_sel == CPMC_SEL_CTRL) begin
            ctrl_next = sreg_wdata[CPMC_CTRL_W-1:0];
        end
        if (exc_enter) begin
            state_next = CPMC_PRIV_HANDLER;
        end else begin
            unique case (state_reg)
                CPMC_PRIV_HANDLER: begin
                    if (exc_return) begin
                        state_next = ctrl_next[CPMC_CTRL_NPRIV] ?
                            CPMC_USER_THREAD : CPMC_PRIV_THREAD;
                    end
                end
                CPMC_PRIV_THREAD: begin
                    if (ctrl_next[CPMC_CTRL_NPRIV]) begin
                        state_next = CPMC_USER_THREAD;
                    end
                end
                // User cannot raise itself; only an exception does
                CPMC_USER_THREAD: state_next = CPMC_USER_THREAD;
                default:          state_next = CPMC_PRIV_THREAD;
            endcase
        end
    end

    // Stack pointer banking and special register writes
    always_comb begin
        main_sp_next = main_stack_pointer_reg;
        proc_sp_next = process_stack_pointer_reg;
        if (priv_wr && sreg_sel == CPMC_SEL_MSP) begin
            main_sp_next = sreg_al;
        end
        if (priv_wr && sreg_sel == CPMC_SEL_PSP) begin
            proc_sp_next = sreg_al;
        end
        if (sp_wr && use_psp) begin
            proc_sp_next = sp_aligned;
        end else if (sp_wr) begin
            main_sp_next = sp_aligned;
        end
    end

    // Read mux and fault
    always_comb begin
        unique case (sreg_sel)
            CPMC_SEL_MSP:  rdata_next = main_stack_pointer_reg;
            CPMC_SEL_PSP:  rdata_next = process_stack_pointer_reg;
            CPMC_SEL_CTRL: rdata_next = {{(DATA_W-CPMC_CTRL_W){1'b0}},
                                         ctrl_reg};
            CPMC_SEL_ESR:  rdata_next = DATA_W'(CPMC_ESR_RST);
            default:       rdata_next = '0;
        endcase
        if (user_block || !sreg_rd) begin
            rdata_next = '0;
        end
        fault_next = user_block | legacy_flt | esr_clear;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset lands in privileged thread on the main stack pointer
    always_ff @(posedge clk or posedge rst_any) begin
        if (rst_any) begin
            state_reg                 <= CPMC_PRIV_THREAD;
            ctrl_reg                  <= CPMC_CTRL_RST;
            main_stack_pointer_reg    <= DATA_W'(CPMC_SP_RST);
            process_stack_pointer_reg <= DATA_W'(CPMC_SP_RST);
            fault_reg                 <= 1'b0;
            sreg_rdata_reg            <= '0;
        end else begin
            state_reg                 <= state_next;
            ctrl_reg                  <= ctrl_next;
            main_stack_pointer_reg    <= main_sp_next;
            process_stack_pointer_reg <= proc_sp_next;
            fault_reg                 <= fault_next;
            sreg_rdata_reg            <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Bit-band and unaligned store datapath
    // ------------------------------------------------------------
    // Single-bit merge in one step, so no software read-modify-write
    logic [DATA_W-1:0] bb_merge;
    for (genvar i = 0; i < DATA_W; i++) begin : g_bb
        assign bb_merge[i] = (bb_idx == CPMC_BB_IDX_W'(i)) ?
                             bb_bit : bb_old_word[i];
    end
    // Byte shift across two words; no padding to natural alignment
    wire [2*DATA_W-1:0] st_shift = {{DATA_W{1'b0}}, st_data} <<
                                   {st_offset, 3'b000};

    always_ff @(posedge clk or posedge rst_any) begin
        if (rst_any) begin
            bb_word_reg  <= '0;
            bb_bit_reg   <= 1'b0;
            st_lanes_reg <= '0;
        end else begin
            bb_word_reg  <= bb_wr ? bb_merge : bb_old_word;
            bb_bit_reg   <= bb_old_word[bb_idx];
            st_lanes_reg <= st_shift;
        end
    end

    // Outputs
    assign active_sp     = use_psp ? process_stack_pointer_reg
                                   : main_stack_pointer_reg;
    assign sp_is_process = use_psp;
    assign privileged    = ~is_user;
    assign handler_mode  = is_handler;
    assign fault         = fault_reg;
    assign sreg_rdata    = sreg_rdata_reg;
    assign bb_new_word   = bb_word_reg;
    assign bb_rd_bit     = bb_bit_reg;
    assign st_lanes      = st_lanes_reg;
endmodule

// ==== tb/cpmc_core_checker.sv ====
// Purpose: Assertions on level, mode, stack select and fault pulses
// Assumes: Sees only the ports of cpmc_core
// Notes:   Bound below the module
`timescale 1ns/1ps
module cpmc_checker
    import cpmc_pkg::*;
#(
    parameter int DATA_W = CPMC_DATA_W
) (
    // Clock and resets
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              external_reset_n,
    // Requests
    input wire logic              exc_enter,
    input wire logic              instr_valid,
    input wire logic              instr_legacy,
    input wire logic              sreg_rd,
    input wire logic              sreg_wr,
    input wire logic [2:0]        sreg_sel,
    input wire logic              prot_access,
    // Results
    input wire logic [DATA_W-1:0] sreg_rdata,
    input wire logic              sp_is_process,
    input wire logic              privileged,
    input wire logic              handler_mode,
    input wire logic              fault
);
    // ------------------------------------------
    // Properties
    // ------------------------------------------
    // Either reset pauses all checks, both act asynchronously
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst || !external_reset_n);
    no_user_handler_a: assert property (handler_mode |-> privileged)
        else $error("handler mode at user level");
    psp_select_a: assert property (sp_is_process == (!privileged &&
        !handler_mode)) else $error("wrong stack pointer selected");
    user_fault_a: assert property (!privileged && !exc_enter &&
        (prot_access || sreg_rd) |=> fault) else $error("no user fault");
    user_read_zero_a: assert property (!privileged && sreg_rd &&
        !exc_enter |=> sreg_rdata == '0) else $error("user read leaked");
    legacy_fault_a: assert property (instr_valid && instr_legacy
        |=> fault) else $error("legacy encoding not faulted");
    enter_handler_a: assert property (exc_enter |=>
        handler_mode && privileged) else $error("no handler entry");
    status_read_a: assert property (privileged && sreg_rd && !exc_enter &&
        sreg_sel == CPMC_SEL_ESR |=> sreg_rdata == CPMC_ESR_RST)
        else $error("status read wrong");
    priv_no_fault_a: assert property (privileged && !sreg_wr &&
        !(instr_valid && instr_legacy) |=> !fault) else $error("priv fault");
    // Main scenarios reached
    cover property (exc_enter ##1 handler_mode);
    cover property (sp_is_process ##1 fault);
    cover property (privileged && sreg_rd ##1 sreg_rdata != '0);
endmodule
bind cpmc_core cpmc_checker #(.DATA_W(DATA_W)) chk_u (.clk(clk),
    .sys_rst(sys_rst), .external_reset_n(external_reset_n),
    .exc_enter(exc_enter), .instr_valid(instr_valid),
    .instr_legacy(instr_legacy), .sreg_rd(sreg_rd), .sreg_wr(sreg_wr),
    .sreg_sel(sreg_sel), .prot_access(prot_access), .fault(fault),
    .sreg_rdata(sreg_rdata), .sp_is_process(sp_is_process),
    .privileged(privileged), .handler_mode(handler_mode));

// ==== tb/cpu_privilege_mode_control_tb.sv ====
// Purpose: Directed bench for privilege, mode and fault control
// Assumes: Requests are one-cycle pulses, results one cycle later
// Notes:   Each scenario judges its own results
`timescale 1ns/1ps
module cpu_privilege_mode_control_tb import cpmc_pkg::*;;
    logic        clk, sys_rst, external_reset_n, exc_enter, exc_return;
    logic        instr_valid, instr_legacy, instr_protected, sreg_wr;
    logic        sreg_rd, prot_access, sp_wr, bb_wr, bb_bit, fault;
    logic        sp_is_process, privileged, handler_mode, bb_rd_bit;
    logic [2:0]  sreg_sel;
    logic [1:0]  st_offset;
    logic [4:0]  bb_idx;
    logic [31:0] sreg_wdata, sp_wdata, bb_old_word, st_data, sreg_rdata;
    logic [31:0] active_sp, bb_new_word;
    logic [63:0] st_lanes;
    int          fails, n_compared;
    cpmc_core dut_u (.clk, .sys_rst, .external_reset_n, .exc_enter,
        .exc_return, .instr_valid, .instr_legacy, .instr_protected, .sreg_wr,
        .sreg_rd, .sreg_sel, .sreg_wdata, .prot_access, .sp_wr, .sp_wdata,
        .bb_wr, .bb_idx, .bb_bit, .bb_old_word, .st_offset, .st_data,
        .sreg_rdata, .active_sp, .sp_is_process, .privileged, .handler_mode,
        .fault, .bb_new_word, .bb_rd_bit, .st_lanes);
    // ------------------------------------------
    // Compare and drive helpers
    // ------------------------------------------
    task automatic chk1(string nm, logic exp, logic got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic chkw(string nm, logic [63:0] exp, logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Drop pulses at the sampling edge, then let registered results land
    task automatic fin;
        @(posedge clk);
        {exc_enter, exc_return, instr_valid, sreg_wr, sreg_rd} <= '0;
        {prot_access, sp_wr, bb_wr, instr_protected} <= '0;
        #1;
    endtask
    task automatic sreg(logic w, logic [2:0] s, logic [31:0] d);
        @(posedge clk);
        sreg_wr <= w;
        sreg_rd <= !w;
        sreg_sel <= s;
        sreg_wdata <= d;
        fin;
    endtask
    task automatic close_out;
        $display("compared %0d, wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ------------------------------------------
    // Clock, stimulus and watchdog
    // ------------------------------------------
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // About 40 cycles of tests; far longer means a hang
    initial begin
        #200_000;
        fails++;
        close_out;
    end
    initial begin
        {sys_rst, external_reset_n} = 2'h3;
        {exc_enter, exc_return, instr_valid, instr_legacy, sreg_wr} = '0;
        {sreg_rd, prot_access, sp_wr, bb_wr, bb_bit, instr_protected} = '0;
        {sreg_sel, st_offset, bb_idx, sreg_wdata, sp_wdata} = '0;
        {bb_old_word, st_data, fails, n_compared} = '0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'h0;
        #1;
        chk1("privileged", 1'h1, privileged);
        chk1("handler", 1'h0, handler_mode);
        chk1("sp_is_process", 1'h0, sp_is_process);
        // Privileged thread: stack pointers and status open; clearing status bit 24 faults
        sreg(1'h1, CPMC_SEL_MSP, 32'h1000_0003);
        chk1("fault", 1'h0, fault);
        chkw("active_sp", 32'h1000_0000, active_sp);
        sreg(1'h1, CPMC_SEL_PSP, 32'h2000_0008);
        chkw("active_sp", 32'h1000_0000, active_sp);
        sreg(1'h0, CPMC_SEL_ESR, 32'h0);
        chkw("status", CPMC_ESR_RST, sreg_rdata);
        sreg(1'h1, CPMC_SEL_ESR, 32'h0);
        chk1("fault", 1'h1, fault);
        sreg(1'h0, CPMC_SEL_ESR, 32'h0);
        chkw("status", CPMC_ESR_RST, sreg_rdata);
        // Drop to user thread, then try everything protected
        sreg(1'h1, CPMC_SEL_CTRL, 32'h0000_0001);
        chk1("privileged", 1'h0, privileged);
        chkw("active_sp", 32'h2000_0008, active_sp);
        sreg(1'h0, CPMC_SEL_MSP, 32'h0);
        chk1("fault", 1'h1, fault);
        chkw("rdata", 32'h0, sreg_rdata);
        sreg(1'h1, CPMC_SEL_CTRL, 32'h0);
        chk1("privileged", 1'h0, privileged);
        @(posedge clk);
        prot_access <= 1'h1;
        instr_valid <= 1'h1;
        instr_protected <= 1'h1;
        fin;
        chk1("fault", 1'h1, fault);
        // Exception entry and return
        @(posedge clk);
        exc_enter <= 1'h1;
        fin;
        chk1("handler", 1'h1, handler_mode);
        chk1("privileged", 1'h1, privileged);
        chkw("active_sp", 32'h1000_0000, active_sp);
        // Push/pop in handler moves the main pointer only
        @(posedge clk);
        sp_wr <= 1'h1;
        sp_wdata <= 32'h1000_0103;
        fin;
        chkw("active_sp", 32'h1000_0100, active_sp);
        @(posedge clk);
        exc_return <= 1'h1;
        fin;
        chk1("handler", 1'h0, handler_mode);
        chk1("sp_is_process", 1'h1, sp_is_process);
        chkw("active_sp", 32'h2000_0008, active_sp);
        // Push/pop in user thread moves the process pointer
        @(posedge clk);
        sp_wr <= 1'h1;
        sp_wdata <= 32'h2000_0105;
        fin;
        chkw("active_sp", 32'h2000_0104, active_sp);
        // Pin reset from user thread, low level acts at once
        @(posedge clk);
        external_reset_n <= 1'h0;
        #1;
        chk1("privileged", 1'h1, privileged);
        @(posedge clk);
        external_reset_n <= 1'h1;
        // Decode, bit-band merge and unaligned lanes in one cycle
        @(posedge clk);
        {instr_valid, instr_legacy, bb_wr, bb_idx} <= 8'hFF;
        {bb_bit, bb_old_word, st_offset} <= {1'h0, 32'hFFFF_FFFF, 2'h3};
        st_data <= 32'h1122_3344;
        fin;
        chk1("fault", 1'h1, fault);
        chkw("bb_new_word", 32'h7FFF_FFFF, bb_new_word);
        chk1("bb_rd_bit", 1'h1, bb_rd_bit);
        chkw("st_lanes", 64'h0011_2233_4400_0000, st_lanes);
        close_out;
    end
endmodule
